// ==== rtl/ssd_decode.sv ====
// Segment selector decode: holds segment registers, emits descriptor lookups,
// and forms physical addresses from held base plus an unsigned offset.
// Assumes the lookup side returns a 24-bit segment base with a one-cycle valid pulse.
// Assumes every input is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module ssd_decode
  import ssd_pkg::*;
#(
  parameter int NUM_SEGREG = SSD_NUM_SEGREG
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Mode and table base registers
  input wire logic prot_mode,
  input wire logic [SSD_PHYS_W-1:0] global_table_base_reg,
  input wire logic [SSD_PHYS_W-1:0] local_table_base_reg,
  // Selector load request
  input wire logic load_valid,
  input wire logic [$clog2(NUM_SEGREG)-1:0] load_seg,
  input wire logic [SSD_SEL_W-1:0] load_selector,
  output logic load_busy,
  // Descriptor lookup
  output logic desc_req,
  output logic [SSD_PHYS_W-1:0] desc_addr,
  output logic desc_table_select_bit,
  input wire logic desc_valid,
  input wire logic [SSD_PHYS_W-1:0] desc_base,
  // Access request
  input wire logic acc_valid,
  input wire logic [$clog2(NUM_SEGREG)-1:0] acc_seg,
  input wire logic [SSD_OFS_W-1:0] acc_offset,
  output logic phys_valid,
  output logic [SSD_PHYS_W-1:0] phys_addr,
  output ssd_ptr_t phys_ptr
);

  // ************************************************************
  // Parameter checks
  // ************************************************************
  localparam int SW = $clog2(NUM_SEGREG);

  // A count that is not a power of two leaves select codes that index past the arrays.
  if (NUM_SEGREG < 2) begin : g_chk_min
    $error("NUM_SEGREG must be at least 2");
  end
  if (NUM_SEGREG != (1 << SW)) begin : g_chk_pow2
    $error("NUM_SEGREG must be a power of two");
  end

  // ************************************************************
  // Address arithmetic
  // ************************************************************
  // Offset is zero-extended, never sign-extended, so offsets above 7FFF stay positive.
  function automatic logic [SSD_PHYS_W-1:0] seg_add(input logic [SSD_PHYS_W-1:0] base,
                                                    input logic [SSD_OFS_W-1:0] ofs);
    seg_add = base + {{(SSD_PHYS_W-SSD_OFS_W){1'b0}}, ofs};
  endfunction : seg_add

  function automatic logic [SSD_PHYS_W-1:0] real_base(input logic [SSD_SEL_W-1:0] sel);
    real_base = {{(SSD_PHYS_W-SSD_SEL_W-SSD_REAL_SHIFT){1'b0}}, sel,
                 {SSD_REAL_SHIFT{1'b0}}};
  endfunction : real_base

  // ************************************************************
  // Selector field split
  // ************************************************************
  ssd_segid_t split_id;
  logic [SSD_PHYS_W-1:0] split_addr;

  ssd_field_split u_split (
    .selector(load_selector),
    .global_base(global_table_base_reg),
    .local_base(local_table_base_reg),
    .seg_id(split_id),
    .desc_addr(split_addr)
  );

  // ************************************************************
  // Segment registers and load sequencer
  // ************************************************************
  // At most one lookup is outstanding, so two states suffice.
  typedef enum logic {SSD_IDLE, SSD_WAIT} ssd_state_t;

  ssd_state_t state_q, state_d;
  logic [SSD_SEL_W-1:0] sel_q [NUM_SEGREG];
  logic [SSD_SEL_W-1:0] sel_d [NUM_SEGREG];
  logic [SSD_PHYS_W-1:0] base_q [NUM_SEGREG];
  logic [SSD_PHYS_W-1:0] base_d [NUM_SEGREG];
  logic [SW-1:0] pend_q, pend_d;
  logic [SSD_SEL_W-1:0] pend_sel_q, pend_sel_d;
  logic desc_req_q, desc_req_d;
  logic [SSD_PHYS_W-1:0] desc_addr_q, desc_addr_d;
  logic desc_tsel_q, desc_tsel_d;

  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    base_d = base_q;
    pend_d = pend_q;
    pend_sel_d = pend_sel_q;
    desc_req_d = 1'b0;
    desc_addr_d = desc_addr_q;
    desc_tsel_d = desc_tsel_q;
    unique case (state_q)
      SSD_IDLE: begin
        if (load_valid) begin
          if (prot_mode) begin
            // Protected mode: fetch the descriptor before the register becomes usable.
            pend_d = load_seg;
            pend_sel_d = load_selector;
            desc_req_d = 1'b1;
            desc_addr_d = split_addr;
            desc_tsel_d = split_id.table_select_bit;
            state_d = SSD_WAIT;
          end else begin
            // Real mode needs no lookup, so the register is usable at the next edge.
            sel_d[load_seg] = load_selector;
            base_d[load_seg] = real_base(load_selector);
          end
        end
      end
      SSD_WAIT: begin
        // A load that arrives while the lookup is outstanding is dropped, not queued.
        // Callers must wait for load_busy to fall before the next protected load.
        if (desc_valid) begin
          sel_d[pend_q] = pend_sel_q;
          base_d[pend_q] = desc_base;
          state_d = SSD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= SSD_IDLE;
      for (int i = 0; i < NUM_SEGREG; i++) begin
        sel_q[i] <= SSD_SEL_RST;
        base_q[i] <= SSD_BASE_RST;
      end
      pend_q <= '0;
      pend_sel_q <= SSD_SEL_RST;
      desc_req_q <= 1'b0;
      desc_addr_q <= SSD_BASE_RST;
      desc_tsel_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      base_q <= base_d;
      pend_q <= pend_d;
      pend_sel_q <= pend_sel_d;
      desc_req_q <= desc_req_d;
      desc_addr_q <= desc_addr_d;
      desc_tsel_q <= desc_tsel_d;
    end
  end

  // ************************************************************
  // Access path
  // ************************************************************
  // Accesses use only the held selector and base; the address carries 16 offset bits.
  // An access taken at the edge where a load completes still sees the old contents.
  logic phys_valid_q, phys_valid_d;
  logic [SSD_PHYS_W-1:0] phys_addr_q, phys_addr_d;
  ssd_ptr_t phys_ptr_q, phys_ptr_d;
  logic busy_q, busy_d;

  always_comb begin
    phys_valid_d = acc_valid;
    phys_addr_d = phys_addr_q;
    phys_ptr_d = phys_ptr_q;
    busy_d = (state_d == SSD_WAIT);
    if (acc_valid) begin
      phys_addr_d = seg_add(base_q[acc_seg], acc_offset);
      phys_ptr_d = '{selector: sel_q[acc_seg], offset: acc_offset};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phys_valid_q <= 1'b0;
      phys_addr_q <= SSD_BASE_RST;
      phys_ptr_q <= '0;
      busy_q <= 1'b0;
    end else begin
      phys_valid_q <= phys_valid_d;
      phys_addr_q <= phys_addr_d;
      phys_ptr_q <= phys_ptr_d;
      busy_q <= busy_d;
    end
  end

  // ************************************************************
  // Output registers
  // ************************************************************
  assign load_busy = busy_q;
  assign desc_req = desc_req_q;
  assign desc_addr = desc_addr_q;
  assign desc_table_select_bit = desc_tsel_q;
  assign phys_valid = phys_valid_q;
  assign phys_addr = phys_addr_q;
  assign phys_ptr = phys_ptr_q;

endmodule : ssd_decode
`default_nettype wire

// ==== rtl/ssd_field_split.sv ====
// Combinational split of a selector into its fields and the descriptor address.
// Assumes the table bases come from the caller's table base registers.
`timescale 1ns/1ps
`default_nettype none
module ssd_field_split
  import ssd_pkg::*;
(
  // Selector in
  input wire logic [SSD_SEL_W-1:0] selector,
  // Table bases
  input wire logic [SSD_PHYS_W-1:0] global_base,
  input wire logic [SSD_PHYS_W-1:0] local_base,
  // Decoded
  output ssd_segid_t seg_id,
  output logic [SSD_PHYS_W-1:0] desc_addr
);
  ssd_sel_t sel;
  logic [SSD_PHYS_W-1:0] scaled;

  always_comb begin
    sel = ssd_sel_t'(selector);
    // The privilege field is dropped here so it can never steer selection.
    seg_id = '{table_select_bit: sel.table_select_bit, index: sel.index};
    scaled = SSD_PHYS_W'(sel.index) << SSD_DESC_SHIFT;
    if (sel.table_select_bit) begin
      desc_addr = local_base + scaled;
    end else begin
      desc_addr = global_base + scaled;
    end
  end
endmodule : ssd_field_split
`default_nettype wire

// ==== rtl/ssd_pkg.sv ====
// Package for the segment selector decode block: selector layout, widths, reset values.
// Assumes it is compiled before every module that imports it.
package ssd_pkg;

  // ************************************************************
  // Widths and selector layout
  // ************************************************************
  localparam int SSD_SEL_W = 16;
  localparam int SSD_OFS_W = 16;
  localparam int SSD_PTR_W = 32;
  localparam int SSD_PHYS_W = 24;
  localparam int SSD_IDX_W = 13;
  localparam int SSD_PRIV_LSB = 0;
  localparam int SSD_PRIV_W = 2;
  localparam int SSD_TSEL_BIT = 2;
  localparam int SSD_IDX_LSB = 3;
  localparam int SSD_DESC_SHIFT = 3;
  localparam int SSD_REAL_SHIFT = 4;
  localparam int SSD_NUM_SEGREG = 4;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [SSD_SEL_W-1:0] SSD_SEL_RST = 16'h0000;
  localparam logic [SSD_PHYS_W-1:0] SSD_BASE_RST = 24'h000000;

  typedef enum logic {SSD_MODE_REAL, SSD_MODE_PROT} ssd_mode_t;

  typedef struct packed {
    logic [SSD_IDX_W-1:0] index;
    logic table_select_bit;
    logic [SSD_PRIV_W-1:0] requested_privilege_field;
  } ssd_sel_t;

  typedef struct packed {
    logic [SSD_SEL_W-1:0] selector;
    logic [SSD_OFS_W-1:0] offset;
  } ssd_ptr_t;

  typedef struct packed {
    logic table_select_bit;
    logic [SSD_IDX_W-1:0] index;
  } ssd_segid_t;

endpackage : ssd_pkg

// ==== testbench/ssd_decode_monitor.sv ====
// Checker for ssd_decode: lookup and access timing and address relations.
// Assumes table bases and mode stay steady while a lookup or access is pending.
`timescale 1ns/1ps
`default_nettype none
module ssd_decode_monitor
  import ssd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Load and lookup
  input wire logic prot_mode,
  input wire logic [SSD_PHYS_W-1:0] global_table_base_reg,
  input wire logic [SSD_PHYS_W-1:0] local_table_base_reg,
  input wire logic load_valid,
  input wire logic [SSD_SEL_W-1:0] load_selector,
  input wire logic load_busy,
  input wire logic desc_req,
  input wire logic [SSD_PHYS_W-1:0] desc_addr,
  input wire logic desc_table_select_bit,
  input wire logic desc_valid,
  // Access
  input wire logic acc_valid,
  input wire logic [SSD_OFS_W-1:0] acc_offset,
  input wire logic phys_valid,
  input wire logic [SSD_PHYS_W-1:0] phys_addr,
  input wire ssd_ptr_t phys_ptr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_PHYS_NEXT: assert property (acc_valid |=> phys_valid)
    else $error("access not answered");
  AST_PHYS_CAUSE: assert property (phys_valid |-> $past(acc_valid))
    else $error("answer without access");
  AST_PTR_OFS: assert property (acc_valid |=> phys_ptr.offset == $past(acc_offset))
    else $error("pointer offset wrong");
  AST_REAL_SUM: assert property (phys_valid && !prot_mode |->
    phys_addr == {4'h0, phys_ptr.selector, 4'h0} + {8'h00, phys_ptr.offset})
    else $error("real mode address wrong");
  AST_DESC_ADDR: assert property (desc_req |-> desc_addr ==
    (desc_table_select_bit ? local_table_base_reg : global_table_base_reg)
    + ({8'h00, $past(load_selector)} & 24'h00FFF8))
    else $error("descriptor address wrong");
  AST_TSEL: assert property (desc_req |->
    desc_table_select_bit == (($past(load_selector) & 16'h0004) != 16'h0000))
    else $error("table choice wrong");
  AST_REQ_CAUSE: assert property (desc_req |-> $past(load_valid) && $past(prot_mode))
    else $error("lookup without protected load");
  AST_REQ_PULSE: assert property (desc_req |=> !desc_req && load_busy)
    else $error("lookup request not a pulse");
  AST_BUSY_END: assert property (load_busy && desc_valid |=> !load_busy)
    else $error("busy stuck after answer");
endmodule : ssd_decode_monitor
bind ssd_decode ssd_decode_monitor u_mon (.clk, .rstn, .prot_mode, .global_table_base_reg,
  .local_table_base_reg, .load_valid, .load_selector, .load_busy, .desc_req, .desc_addr,
  .desc_table_select_bit, .desc_valid, .acc_valid, .acc_offset, .phys_valid, .phys_addr,
  .phys_ptr);
`default_nettype wire

// ==== testbench/ssd_lookup_model.sv ====
// Descriptor table lookup model: answers a request after a chosen wait.
// Assumes the address is held from the request until the answer.
`timescale 1ns/1ps
`default_nettype none
module ssd_lookup_model
  import ssd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Lookup channel
  input wire logic desc_req,
  input wire logic [SSD_PHYS_W-1:0] desc_addr,
  input wire logic [3:0] wait_cycles,
  output logic desc_valid,
  output logic [SSD_PHYS_W-1:0] desc_base
);
  logic busy_q;
  logic [3:0] cnt_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      desc_valid <= 1'b0;
      desc_base <= 24'h000000;
    end else begin
      desc_valid <= 1'b0;
      // Outside an answer the base toggles, so a stale capture shows up.
      desc_base <= ~desc_base;
      if (desc_req) begin
        busy_q <= 1'b1;
        cnt_q <= wait_cycles;
      end else if (busy_q && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        desc_valid <= 1'b1;
        desc_base <= desc_addr ^ 24'hA5A5A0;
      end
    end
  end
endmodule : ssd_lookup_model
`default_nettype wire

// ==== testbench/tb.sv ====
// Testbench for ssd_decode: reset, real mode and protected mode decode.
// Assumes the lookup model answers with the table entry address scrambled.
`timescale 1ns/1ps
`default_nettype none
module tb
  import ssd_pkg::*;
;
  logic clk, rstn, prot_mode, load_valid, load_busy, desc_req, desc_table_select_bit;
  logic desc_valid, acc_valid, phys_valid;
  logic [1:0] load_seg, acc_seg;
  logic [15:0] load_selector, acc_offset;
  logic [23:0] global_table_base_reg, local_table_base_reg, desc_addr, desc_base, phys_addr;
  logic [3:0] wait_cycles;
  ssd_ptr_t phys_ptr;
  int n_mismatch, samples_checked;
  ssd_decode u_dut (.clk, .rstn, .prot_mode, .global_table_base_reg, .local_table_base_reg,
    .load_valid, .load_seg, .load_selector, .load_busy, .desc_req, .desc_addr,
    .desc_table_select_bit, .desc_valid, .desc_base, .acc_valid, .acc_seg, .acc_offset,
    .phys_valid, .phys_addr, .phys_ptr);
  ssd_lookup_model u_lkp (.clk, .rstn, .desc_req, .desc_addr, .wait_cycles, .desc_valid,
    .desc_base);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic ld(input logic [1:0] s, input logic [15:0] sel);
    @(negedge clk);
    load_seg = s;
    load_selector = sel;
    load_valid = 1'b1;
    @(negedge clk);
    load_valid = 1'b0;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 40 && load_busy !== 1'b0; i++) @(negedge clk);
    chk({31'h0, load_busy}, 32'h0);
  endtask : ld
  task automatic acc(input logic [1:0] s, input logic [15:0] ofs, input logic [23:0] ea,
    input logic [15:0] es);
    @(negedge clk);
    acc_seg = s;
    acc_offset = ofs;
    acc_valid = 1'b1;
    @(negedge clk);
    acc_valid = 1'b0;
    chk({31'h0, phys_valid}, 32'h1);
    chk({8'h0, phys_addr}, {8'h0, ea});
    chk(phys_ptr, {es, ofs});
  endtask : acc
  task automatic t_real();
    prot_mode = 1'b0;
    ld(2'h1, 16'hF000);
    ld(2'h2, 16'hFFFF);
    acc(2'h1, 16'hFFFF, 24'h0FFFFF, 16'hF000);
    acc(2'h2, 16'hFFFF, 24'h10FFEF, 16'hFFFF);
  endtask : t_real
  task automatic t_prot();
    logic [15:0] sel;
    logic [23:0] ent;
    prot_mode = 1'b1;
    for (int k = 0; k < 8; k++) begin
      sel = {(k[0] ? 13'h1FFF : 13'h0000), k[1], k[2], k[0]};
      ent = (k[1] ? local_table_base_reg : global_table_base_reg) + {8'h0, sel & 16'hFFF8};
      wait_cycles = 4'(k * 2);
      ld(k[1:0], sel);
      chk({8'h0, desc_addr}, {8'h0, ent});
      chk({31'h0, desc_table_select_bit}, {31'h0, k[1]});
      acc(k[1:0], 16'h8000 + 16'(k), (ent ^ 24'hA5A5A0) + 24'h008000 + 24'(k), sel);
    end
  endtask : t_prot
  task automatic t_reset();
    rstn = 1'b0;
    repeat (4) @(negedge clk);
    chk({31'h0, desc_req}, 32'h0);
    chk({8'h0, desc_addr}, 32'h0);
    chk({31'h0, desc_table_select_bit}, 32'h0);
    chk({31'h0, phys_valid}, 32'h0);
    chk({8'h0, phys_addr}, 32'h0);
    chk(phys_ptr, 32'h0);
    chk({31'h0, load_busy}, 32'h0);
    rstn = 1'b1;
    acc(2'h0, 16'h1234, 24'h001234, 16'h0000);
  endtask : t_reset
  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end
  initial begin
    {prot_mode, load_valid, acc_valid, load_seg, acc_seg} = '0;
    {load_selector, acc_offset, wait_cycles} = '0;
    global_table_base_reg = 24'h100000;
    local_table_base_reg = 24'h200000;
    t_reset();
    t_real();
    t_prot();
    t_reset();
    final_report();
  end
endmodule : tb
`default_nettype wire
